// ===== rtl/pio_defines.vh
/*
 Constants for the shared parallel I/O port block: register indices,
 implemented-bit masks, reset values and analog-capable pin mask.
 Assumes the includer works on 16-bit ports B to F, five in all.
*/
// Operation
// - a pin actively driven by an enabled peripheral has its port driver off
// - enabled but idle peripheral lets the port logic drive the pin
// - direction bit 1 makes the pin input, 0 drives it from the latch
// - every implemented pin becomes an input after any reset
// - latch register reads return latch contents; writes update the latch
// - pin-state reads return pin levels; writes update the output latch
// - bits not valid on the device read zero in latch, direction and pins
// - per-pin multiplexer pair hands pad data and enable to peripheral first
// - pins shared only with input functions act as dedicated port pins
// - pins selected as analog channels read as zero in pin-state reads
// - pins configured as digital inputs are not routed to the converter
// - unimplemented bits in all port registers read zero and ignore writes
`ifndef PIO_DEFINES_VH
`define PIO_DEFINES_VH

`define PORT_W 16
`define PORT_N 5

`define IDX_DIR_B 10'h2C6
`define IDX_PIN_B 10'h2C8
`define IDX_LAT_B 10'h2CA
`define IDX_DIR_C 10'h2CC
`define IDX_PIN_C 10'h2CE
`define IDX_LAT_C 10'h2D0
`define IDX_DIR_D 10'h2D2
`define IDX_PIN_D 10'h2D4
`define IDX_LAT_D 10'h2D6
`define IDX_DIR_E 10'h2D8
`define IDX_PIN_E 10'h2DA
`define IDX_LAT_E 10'h2DC
`define IDX_DIR_F 10'h2DE
`define IDX_PIN_F 10'h2E0
`define IDX_LAT_F 10'h2E2

`define IMPL_B 16'h01FF
`define IMPL_C 16'hE000
`define IMPL_D 16'h000F
`define IMPL_E 16'h013F
`define IMPL_F 16'h007F
`define IMPL_ALL {`IMPL_F, `IMPL_E, `IMPL_D, `IMPL_C, `IMPL_B}

`define DIR_RST_B 16'h01FF
`define DIR_RST_C 16'hE000
`define DIR_RST_D 16'h000F
`define DIR_RST_E 16'h013F
`define DIR_RST_F 16'h007F
`define LAT_RST 16'h0000

`define ANALOG_CAP_B 16'h01FF
`define ANALOG_CAP_ALL {64'h0000000000000000, `ANALOG_CAP_B}

`define KIND_DIR 2'h0
`define KIND_PIN 2'h1
`define KIND_LAT 2'h2

`endif

// ===== rtl/shared_parallel_io_port.v
/*
 Shared parallel I/O ports B to F with a classic Wishbone register slave.
 Assumes pad inputs and peripheral signals are synchronous to clk_i;
 pin vectors pack port B in bits 15:0 up to port F in bits 79:64.
*/
`timescale 1ns/1ps
`include "pio_defines.vh"

module shared_parallel_io_port (
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [11:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output wire [31:0] dat_o,
	output wire ack_o,
	input wire [79:0] pad_in_i,
	input wire [79:0] periph_en_i,
	input wire [79:0] periph_drive_i,
	input wire [79:0] periph_out_i,
	input wire [79:0] analog_pin_select_i,
	output wire [79:0] pad_out_o,
	output wire [79:0] pad_oe_o,
	output wire [79:0] adc_route_o
);

	// decode: {hit, port[2:0], kind[1:0]}
	function [5:0] decode;
		input [9:0] idx;
		begin
			case (idx)
			`IDX_DIR_B: begin
				decode = {1'b1, 3'h0, `KIND_DIR};
			end
			`IDX_PIN_B: begin
				decode = {1'b1, 3'h0, `KIND_PIN};
			end
			`IDX_LAT_B: begin
				decode = {1'b1, 3'h0, `KIND_LAT};
			end
			`IDX_DIR_C: begin
				decode = {1'b1, 3'h1, `KIND_DIR};
			end
			`IDX_PIN_C: begin
				decode = {1'b1, 3'h1, `KIND_PIN};
			end
			`IDX_LAT_C: begin
				decode = {1'b1, 3'h1, `KIND_LAT};
			end
			`IDX_DIR_D: begin
				decode = {1'b1, 3'h2, `KIND_DIR};
			end
			`IDX_PIN_D: begin
				decode = {1'b1, 3'h2, `KIND_PIN};
			end
			`IDX_LAT_D: begin
				decode = {1'b1, 3'h2, `KIND_LAT};
			end
			`IDX_DIR_E: begin
				decode = {1'b1, 3'h3, `KIND_DIR};
			end
			`IDX_PIN_E: begin
				decode = {1'b1, 3'h3, `KIND_PIN};
			end
			`IDX_LAT_E: begin
				decode = {1'b1, 3'h3, `KIND_LAT};
			end
			`IDX_DIR_F: begin
				decode = {1'b1, 3'h4, `KIND_DIR};
			end
			`IDX_PIN_F: begin
				decode = {1'b1, 3'h4, `KIND_PIN};
			end
			`IDX_LAT_F: begin
				decode = {1'b1, 3'h4, `KIND_LAT};
			end
			default: begin
				decode = 6'h00;
			end
			endcase
		end
	endfunction

	function [15:0] impl_mask;
		input [2:0] p;
		begin
			case (p)
			3'h0: begin
				impl_mask = `IMPL_B;
			end
			3'h1: begin
				impl_mask = `IMPL_C;
			end
			3'h2: begin
				impl_mask = `IMPL_D;
			end
			3'h3: begin
				impl_mask = `IMPL_E;
			end
			3'h4: begin
				impl_mask = `IMPL_F;
			end
			default: begin
				impl_mask = 16'h0000;
			end
			endcase
		end
	endfunction

	function [15:0] dir_reset;
		input [2:0] p;
		begin
			case (p)
			3'h0: begin
				dir_reset = `DIR_RST_B;
			end
			3'h1: begin
				dir_reset = `DIR_RST_C;
			end
			3'h2: begin
				dir_reset = `DIR_RST_D;
			end
			3'h3: begin
				dir_reset = `DIR_RST_E;
			end
			3'h4: begin
				dir_reset = `DIR_RST_F;
			end
			default: begin
				dir_reset = 16'h0000;
			end
			endcase
		end
	endfunction

	// byte-lane merge of a write into a 16-bit register
	function [15:0] merge;
		input [15:0] old;
		input [15:0] wdat;
		input [1:0] sel;
		begin
			merge[7:0] = sel[0] ? wdat[7:0] : old[7:0];
			merge[15:8] = sel[1] ? wdat[15:8] : old[15:8];
		end
	endfunction

	reg [15:0] dir_reg [0:4];
	reg [15:0] lat_reg [0:4];
	reg ack_reg;
	reg [31:0] dat_reg;
	reg [79:0] pad_out_reg;
	reg [79:0] pad_oe_reg;
	reg [79:0] adc_route_reg;
	integer i;

	wire [79:0] impl_all = `IMPL_ALL;
	wire [79:0] analog_on = analog_pin_select_i & `ANALOG_CAP_ALL;
	wire [5:0] dec = decode(adr_i[11:2]);
	wire hit = dec[5];
	wire [2:0] port = dec[4:2];
	wire [1:0] kind = dec[1:0];
	wire take = cyc_i & stb_i & ~ack_reg;
	wire [15:0] mask = impl_mask(port);
	wire [15:0] pins_now = pad_in_i[port * 16 +: 16];
	wire [15:0] analog_now = analog_on[port * 16 +: 16];
	wire [15:0] pin_view = pins_now & mask & ~analog_now;
	wire [15:0] wr_val = merge(lat_reg[port], dat_i[15:0], sel_i[1:0]);
	wire [15:0] wr_dir = merge(dir_reg[port], dat_i[15:0], sel_i[1:0]);
	wire [79:0] pad_out_next;
	wire [79:0] pad_oe_next;

	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h00000000;
			for (i = 0; i < `PORT_N; i = i + 1) begin
				dir_reg[i] <= dir_reset(i[2:0]);
				lat_reg[i] <= `LAT_RST;
			end
		end else begin
			ack_reg <= take;
			dat_reg <= 32'h00000000;
			if (take && hit && we_i) begin
				if (kind == `KIND_DIR) begin
					dir_reg[port] <= wr_dir & mask;
				end else begin
					lat_reg[port] <= wr_val & mask;
				end
			end
			if (take && hit && !we_i) begin
				case (kind)
				`KIND_DIR: begin
					dat_reg <= {16'h0000, dir_reg[port] & mask};
				end
				`KIND_PIN: begin
					dat_reg <= {16'h0000, pin_view};
				end
				`KIND_LAT: begin
					dat_reg <= {16'h0000, lat_reg[port] & mask};
				end
				default: begin
					dat_reg <= 32'h00000000;
				end
				endcase
			end
		end
	end

	// per-pin output multiplexer pair, peripheral over port
	genvar j;
	generate
		for (j = 0; j < 80; j = j + 1) begin : pad_mux
			wire own = periph_en_i[j] & periph_drive_i[j] & impl_all[j];
			wire dir_bit = dir_reg[j / 16][j % 16];
			wire lat_bit = lat_reg[j / 16][j % 16];
			assign pad_out_next[j] = own ? periph_out_i[j] :
				(lat_bit & impl_all[j]);
			assign pad_oe_next[j] = own ? 1'b1 : (~dir_bit & impl_all[j]);
		end
	endgenerate

	always @(posedge clk_i) begin
		if (rst_i) begin
			pad_out_reg <= 80'h0;
			pad_oe_reg <= 80'h0;
			adc_route_reg <= 80'h0;
		end else begin
			pad_out_reg <= pad_out_next;
			pad_oe_reg <= pad_oe_next;
			adc_route_reg <= analog_on & impl_all;
		end
	end

	assign dat_o = dat_reg;
	assign ack_o = ack_reg;
	assign pad_out_o = pad_out_reg;
	assign pad_oe_o = pad_oe_reg;
	assign adc_route_o = adc_route_reg;

endmodule

// ===== tb/pio_pads.sv
/* pad model: a driven pin shows the pad data, an idle pin the outside level
 assumes the bench supplies the outside level of undriven pins */
`timescale 1ns/1ps
module pio_pads (
	input wire [79:0] out_i,
	input wire [79:0] oe_i,
	input wire [79:0] ext_i,
	output logic [79:0] pin_o
);
	assign pin_o = (out_i & oe_i) | (ext_i & ~oe_i);
endmodule

// ===== tb/shared_parallel_io_port_assertions.sv
/* checker: pad ownership, converter routing and port B read path
 assumes it is bound into shared_parallel_io_port */
`timescale 1ns/1ps
`include "pio_defines.vh"
module pio_checker (
	input wire clk_i,
	input wire rst_i,
	input wire we_i,
	input wire [11:0] adr_i,
	input wire [31:0] dat_o,
	input wire ack_o,
	input wire [79:0] pad_in_i,
	input wire [79:0] periph_en_i,
	input wire [79:0] periph_drive_i,
	input wire [79:0] periph_out_i,
	input wire [79:0] analog_pin_select_i,
	input wire [79:0] pad_out_o,
	input wire [79:0] pad_oe_o,
	input wire [79:0] adc_route_o
);
	wire [79:0] own = periph_en_i & periph_drive_i & `IMPL_ALL;
	wire pin_b = ack_o && !we_i && adr_i[11:2] == `IDX_PIN_B;
	wire [15:0] an = analog_pin_select_i[15:0];
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_own_oe; 1 |=> (pad_oe_o & $past(own)) == $past(own); endproperty
	a_own_oe: assert property (p_own_oe) else $error("oe not given up");
	property p_own_out;
		1 |=> ((pad_out_o ^ $past(periph_out_i)) & $past(own)) == 0;
	endproperty
	a_own_out: assert property (p_own_out) else $error("pad data");
	property p_unimpl; ((pad_oe_o | pad_out_o) & ~`IMPL_ALL) == 0; endproperty
	a_unimpl: assert property (p_unimpl) else $error("unused pin");
	property p_route;
		1 |=> (adc_route_o & ~$past(analog_pin_select_i)) == 0;
	endproperty
	a_route: assert property (p_route) else $error("digital routed");
	property p_cap; (adc_route_o & ~`ANALOG_CAP_ALL) == 0; endproperty
	a_cap: assert property (p_cap) else $error("route mask");
	property p_analog; pin_b |-> (dat_o[15:0] & $past(an) & `IMPL_B) == 0;
	endproperty
	a_analog: assert property (p_analog) else $error("analog pin read");
	property p_pin;
		pin_b |-> dat_o[15:0] == ($past(pad_in_i[15:0]) & ~$past(an) & `IMPL_B);
	endproperty
	a_pin: assert property (p_pin) else $error("pin read");
	property p_reset; $fell(rst_i) |=> (pad_oe_o & ~$past(own)) == 0; endproperty
	a_reset: assert property (p_reset) else $error("pin driven");
endmodule
bind shared_parallel_io_port pio_checker i_chk(.*);

// ===== tb/shared_parallel_io_port_bench.sv
/* bench: random register and pad traffic on every port
 assumes the pio_pads model and the bound checker */
`timescale 1ns/1ps
`include "pio_defines.vh"
module shared_parallel_io_port_bench;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o;
	logic [11:0] adr_i = 0;
	logic [3:0] sel_i = 0;
	logic [31:0] dat_i = 0, dat_o;
	logic [79:0] periph_en_i = 0, periph_drive_i = 0, periph_out_i = 0;
	logic [79:0] analog_pin_select_i = 0, ext = 0, pad_in_i;
	logic [79:0] pad_out_o, pad_oe_o, adc_route_o, all_m = `IMPL_ALL;
	logic [15:0] q, m, d, l, e, x, an, o, v;
	logic [9:0] b;
	int error_cnt = 0, checks = 0, n;
	always #10 clk_i = ~clk_i;
	shared_parallel_io_port i_dut(.*);
	pio_pads i_pads(.out_i(pad_out_o), .oe_i(pad_oe_o), .ext_i(ext),
		.pin_o(pad_in_i));
	task test_done;
		if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task cmp(input string s, input logic [15:0] ex, input logic [15:0] got);
		checks++;
		if (ex !== got) begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", s, ex, got);
		end
	endtask
	task wb(input logic w, input logic [9:0] i, input logic [15:0] wd,
		input logic [1:0] s);
		{cyc_i, stb_i, we_i} <= {2'h3, w};
		adr_i <= {i, 2'h0};
		dat_i <= {16'h0000, wd};
		sel_i <= {2'h0, s};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'h1 && n < 20);
		if (ack_o !== 1'h1) begin
			error_cnt++;
			test_done;
		end
		q = dat_o[15:0];
		{cyc_i, stb_i} <= 2'h0;
		@(posedge clk_i);
	endtask
	task rd(input logic [9:0] i);
		wb(1'h0, i, 16'h0000, 2'h0);
	endtask
	initial begin
		void'($urandom(32'h4C21));
		repeat (20) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		for (int p = 0; p < 5; p++) begin
			b = `IDX_DIR_B + 10'(6 * p);
			m = all_m[16*p +: 16];
			an = p == 0 ? `ANALOG_CAP_B : 16'h0000;
			rd(b);
			cmp("dir reset", m, q);
			rd(b + 10'h4);
			cmp("lat reset", 16'h0000, q);
			repeat (4) begin
				{d, l, x, e} = {$urandom, $urandom};
				d = d | (e & an);
				periph_en_i <= 80'h0;
				ext[16*p +: 16] <= x;
				analog_pin_select_i[16*p +: 16] <= e;
				wb(1'h1, b + 10'h4, l, 2'h3);
				rd(b + 10'h4);
				cmp("lat", l & m, q);
				wb(1'h1, b, d, 2'h3);
				rd(b);
				cmp("dir", d & m, q);
				@(negedge clk_i);
				cmp("oe", ~d & m, pad_oe_o[16*p +: 16]);
				cmp("out", l & m, pad_out_o[16*p +: 16]);
				cmp("route", e & an, adc_route_o[16*p +: 16]);
				@(posedge clk_i);
				rd(b + 10'h2);
				cmp("pin", ((l & ~d) | (x & d)) & m & ~(e & an), q);
				periph_en_i[16*p +: 16] <= e;
				periph_drive_i[16*p +: 16] <= x;
				periph_out_i[16*p +: 16] <= ~l;
				wb(1'h1, b + 10'h2, ~l, 2'h1);
				@(negedge clk_i);
				o = ((e & x & ~l) | (~(e & x) & {l[15:8], ~l[7:0]})) & m;
				v = ((e & x) | ~d) & m;
				cmp("periph oe", v, pad_oe_o[16*p +: 16]);
				cmp("periph out", o, pad_out_o[16*p +: 16]);
				@(posedge clk_i);
				rd(b + 10'h2);
				cmp("periph pin", ((o & v) | (x & ~v)) & m & ~(e & an), q);
				rd(b + 10'h4);
				cmp("pin write", {l[15:8], ~l[7:0]} & m, q);
			end
		end
		rd(10'h000);
		cmp("unmapped", 16'h0000, q);
		test_done;
	end
endmodule
